// ===== logic/csx_defines.svh
// Shared constants for the chip-select and transceiver control block.
// Assumes a 20-bit memory address space with I/O decoded on its low 16 bits.
`ifndef CSX_DEFINES_SVH
`define CSX_DEFINES_SVH
`define CSX_UPPER_LSB    10
`define CSX_UPPER_MAX    4'h8
`define CSX_MID_LSB      13
`define CSX_MID_MAX      3'h6
`define CSX_MID_IDX_LSB  11
`define CSX_PCS_LSB      7
`define CSX_PCS_COUNT    3'h7
`define CSX_SYNC_WIDTH   5
`endif

// ===== logic/csx_pkg.sv
// Types for the chip-select and transceiver control block.
// Assumes nothing beyond the defines header.
package csx_pkg;
  typedef enum logic [3:0] {
    CSX_ST_RST1  = 4'b0001,
    CSX_ST_RST2  = 4'b0010,
    CSX_ST_RUN   = 4'b0100,
    CSX_ST_FLOAT = 4'b1000
  } csx_state_t;
endpackage : csx_pkg

// ===== logic/csx_top.sv
// Chip-select decode, strap-sampled float test mode and transceiver controls.
// Assumes the core presents one bus reference per cycle on the same clock and
// that two-way pins are resolved outside from the output enables.
`include "csx_defines.svh"

// Overview of operation
// - Upper select low inside top block
// - Both straps low at release: float mode
// - Float mode floats every pin until reset
// - Strap pins pulled up only during reset
// - Lower select low inside bottom block
// - Four mid selects cover mid region
// - Enhanced: mid pin 0 is transfer request
// - Enhanced: mid pin 3 is coprocessor select
// - Enhanced: mid pin 1 is error input
// - Five peripheral selects, I/O or memory
// - Pin six: select or latched A1
// - Pin seven: select or latched A2
// - Dual pins keep driving during hold
// - Direction low read, high write
// - Enable low in data phase once direction set
// - Enable high while direction changes
// - Enable driven high one reset clock
// - Hold answered by ack and floating
module csx_top import csx_pkg::*; (
  input  wire logic        REF_CLK_I,                 // 40 MHz clock
  input  wire logic        RST_I,                     // Sync reset, high
  input  wire logic        ENHANCED_MODE_I,           // Coprocessor pin reuse
  input  wire logic        CYCLE_VALID_I,             // Bus reference this cycle
  input  wire logic [19:0] ADDR_I,                    // Reference address
  input  wire logic        MEM_CYCLE_I,               // 1 memory, 0 I/O
  input  wire logic        WRITE_I,                   // Write reference
  input  wire logic        DATA_PHASE_I,              // Data moving on bus
  input  wire logic        COPROC_ACCESS_I,           // Reference to coprocessor
  input  wire logic        HOLD_I,                    // Hold request pin
  input  wire logic [3:0]  UPPER_SIZE_I,              // Top block 1K shl n
  input  wire logic [3:0]  LOWER_SIZE_I,              // Bottom block 1K shl n
  input  wire logic [6:0]  MID_BASE_I,                // Mid base, addr 19:13
  input  wire logic [2:0]  MID_SIZE_I,                // Mid block 8K shl n
  input  wire logic [9:0]  PERIPH_BASE_I,             // Periph base, addr 19:10
  input  wire logic        PERIPH_IN_MEM_I,           // Periph area in memory
  input  wire logic        PERIPH_ADDR_OUT_I,         // Pins six/seven latch A1/A2
  input  wire logic        UPPER_MEM_SELECT_N_I,      // Strap level
  output logic             UPPER_MEM_SELECT_N_O,      // Upper select
  output logic             UPPER_MEM_SELECT_N_OE_O,   // Drive enable
  output logic             UPPER_PULLUP_EN_O,         // Weak pullup on
  input  wire logic        LOWER_MEM_SELECT_N_I,      // Strap level
  output logic             LOWER_MEM_SELECT_N_O,      // Lower select
  output logic             LOWER_MEM_SELECT_N_OE_O,   // Drive enable
  output logic             LOWER_PULLUP_EN_O,         // Weak pullup on
  input  wire logic        MID_SELECT0_N_I,           // Transfer request level
  input  wire logic        MID_SELECT1_N_I,           // Error level
  output logic [3:0]       MID_SELECT_N_O,            // Mid selects 0..3
  output logic [3:0]       MID_SELECT_N_OE_O,         // Drive enables
  output logic             COPROC_TRANSFER_REQUEST_O, // Synced request
  output logic             COPROC_ERROR_O,            // Synced error
  output logic [4:0]       PERIPH_SELECT_N_O,         // Periph selects 0..4
  output logic             PERIPH_SELECT_N_OE_O,      // Drive enable
  output logic             PERIPH_SELECT5_OR_ADDR1_O, // Select five or A1
  output logic             PERIPH_SELECT6_OR_ADDR2_O, // Select six or A2
  output logic             PERIPH_DUAL_OE_O,          // Drive enable, both
  output logic             XCVR_DIRECTION_O,          // High when writing
  output logic             XCVR_DIRECTION_OE_O,       // Drive enable
  output logic             XCVR_ENABLE_N_O,           // Transceiver enable
  output logic             XCVR_ENABLE_N_OE_O,        // Drive enable
  output logic             HOLD_ACK_O,                // Hold granted
  output logic             HOLD_ACK_OE_O,             // Drive enable
  output logic             FLOAT_TEST_MODE_O          // Float mode status
);

  csx_state_t                  state_q;
  logic [`CSX_SYNC_WIDTH-1:0]  sync1_q;
  logic [`CSX_SYNC_WIDTH-1:0]  sync2_q;
  logic                        hold_s;
  logic                        run;
  logic                        drive;
  logic                        in_rst;
  logic                        ref_mem;
  logic                        pref;
  logic [6:0]                  pdec;
  logic                        float_q;
  logic                        ucs_q;
  logic                        lcs_q;
  logic [3:0]                  mcs_q;
  logic [4:0]                  pcs_q;
  logic [1:0]                  dual_q;
  logic                        dir_q;
  logic                        den_q;
  logic                        ack_q;
  logic                        pull_q;
  logic                        oe_q;
  logic                        mid01_oe_q;
  logic                        dual_oe_q;
  logic                        den_oe_q;
  logic                        ack_oe_q;
  logic                        req_q;
  logic                        err_q;

  function automatic logic upper_hit(input logic [9:0] a, input logic [3:0] code);
    logic [3:0] c;
    logic [9:0] m;
    c = (code > `CSX_UPPER_MAX) ? `CSX_UPPER_MAX : code;
    m = 10'h3ff << c;
    return &(a | ~m);
  endfunction : upper_hit

  function automatic logic lower_hit(input logic [9:0] a, input logic [3:0] code);
    logic [3:0] c;
    logic [9:0] m;
    c = (code > `CSX_UPPER_MAX) ? `CSX_UPPER_MAX : code;
    m = 10'h3ff << c;
    return (a & m) == 10'h000;
  endfunction : lower_hit

  // Active-low one-hot of the quarter hit, all high on a miss
  function automatic logic [3:0] mid_dec(input logic [19:0] a, input logic [6:0] base,
                                         input logic [2:0] size);
    logic [2:0] s;
    logic [6:0] m;
    logic [8:0] q;
    s = (size > `CSX_MID_MAX) ? `CSX_MID_MAX : size;
    m = 7'h7f << s;
    q = a[19:`CSX_MID_IDX_LSB] >> s;
    if (((a[19:`CSX_MID_LSB] ^ base) & m) != 7'h00) return 4'hf;
    return ~(4'h1 << q[1:0]);
  endfunction : mid_dec

  // Seven selects of one block each inside a 1K window
  function automatic logic [6:0] periph_dec(input logic [19:0] a, input logic [9:0] base,
                                            input logic in_mem);
    logic       hit;
    logic [2:0] idx;
    hit = in_mem ? (a[19:10] == base) : (a[15:10] == base[5:0]);
    idx = a[9:`CSX_PCS_LSB];
    if (!hit || idx == `CSX_PCS_COUNT) return 7'h7f;
    return ~(7'h01 << idx);
  endfunction : periph_dec

  assign hold_s  = sync2_q[0];
  assign run     = (state_q == CSX_ST_RUN);
  assign in_rst  = (state_q == CSX_ST_RST1) || (state_q == CSX_ST_RST2);
  assign drive   = run && !hold_s;
  assign ref_mem = CYCLE_VALID_I && MEM_CYCLE_I;
  assign pref    = CYCLE_VALID_I && (MEM_CYCLE_I == PERIPH_IN_MEM_I);
  assign pdec    = periph_dec(ADDR_I, PERIPH_BASE_I, PERIPH_IN_MEM_I);

  // Pin inputs: hold, upper strap, lower strap, request, error.
  // Not reset: the strap levels seen at release must be the pins during reset,
  // a reset value of zero would look like both straps pulled low.
  always_ff @(posedge REF_CLK_I) begin
    sync1_q <= {MID_SELECT1_N_I, MID_SELECT0_N_I, LOWER_MEM_SELECT_N_I,
                UPPER_MEM_SELECT_N_I, HOLD_I};
    sync2_q <= sync1_q;
  end

  // Straps are read as synced after release; pullups keep them high in reset
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      float_q <= 1'b0;
      if (in_rst) state_q <= CSX_ST_RST2;
      else        state_q <= CSX_ST_RST1;
    end else begin
      unique case (state_q)
        CSX_ST_RST1, CSX_ST_RST2: begin
          if (!sync2_q[1] && !sync2_q[2]) begin
            state_q <= CSX_ST_FLOAT;
            float_q <= 1'b1;
          end else begin
            state_q <= CSX_ST_RUN;
          end
        end
        CSX_ST_RUN:   state_q <= CSX_ST_RUN;
        CSX_ST_FLOAT: state_q <= CSX_ST_FLOAT;
        default:      state_q <= CSX_ST_RST1;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    pull_q <= RST_I;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ucs_q <= 1'b1;
      lcs_q <= 1'b1;
      mcs_q <= 4'hf;
      pcs_q <= 5'h1f;
    end else begin
      ucs_q <= !(drive && ref_mem && upper_hit(ADDR_I[19:10], UPPER_SIZE_I));
      lcs_q <= !(drive && ref_mem && lower_hit(ADDR_I[19:10], LOWER_SIZE_I));
      mcs_q <= (drive && ref_mem) ? mid_dec(ADDR_I, MID_BASE_I, MID_SIZE_I)
                                  : 4'hf;
      if (ENHANCED_MODE_I) begin
        mcs_q[3] <= !(drive && CYCLE_VALID_I && COPROC_ACCESS_I);
      end
      pcs_q <= (drive && pref) ? pdec[4:0] : 5'h1f;
    end
  end

  // Latched address is frozen during hold, so the pins keep their last value
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      dual_q <= 2'b11;
    end else if (PERIPH_ADDR_OUT_I) begin
      if (drive && CYCLE_VALID_I) dual_q <= ADDR_I[2:1];
    end else begin
      dual_q <= (run && pref) ? pdec[6:5] : 2'b11;
    end
  end

  // Enhanced-mode inputs, already synchronised
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      req_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      req_q <= ENHANCED_MODE_I && run && sync2_q[3];
      err_q <= ENHANCED_MODE_I && run && !sync2_q[4];
    end
  end

  // Direction flips in a cycle with enable high; enable drops a cycle later
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      dir_q <= 1'b0;
      den_q <= 1'b1;
    end else if (drive && DATA_PHASE_I) begin
      if (dir_q != WRITE_I) begin
        dir_q <= WRITE_I;
        den_q <= 1'b1;
      end else begin
        den_q <= 1'b0;
      end
    end else begin
      den_q <= 1'b1;
    end
  end

  // Hold is granted only in the run state, never in float mode; the core must not start cycles while held
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ack_q      <= 1'b0;
      oe_q       <= 1'b0;
      mid01_oe_q <= 1'b0;
      dual_oe_q  <= 1'b0;
      ack_oe_q   <= 1'b0;
      den_oe_q   <= !in_rst;
    end else begin
      ack_q      <= run && hold_s;
      oe_q       <= drive;
      mid01_oe_q <= drive && !ENHANCED_MODE_I;
      dual_oe_q  <= run;
      ack_oe_q   <= run;
      den_oe_q   <= drive;
    end
  end

  assign UPPER_MEM_SELECT_N_O      = ucs_q;
  assign UPPER_MEM_SELECT_N_OE_O   = oe_q;
  assign UPPER_PULLUP_EN_O         = pull_q;
  assign LOWER_MEM_SELECT_N_O      = lcs_q;
  assign LOWER_MEM_SELECT_N_OE_O   = oe_q;
  assign LOWER_PULLUP_EN_O         = pull_q;
  assign MID_SELECT_N_O            = mcs_q;
  assign MID_SELECT_N_OE_O         = {oe_q, oe_q, mid01_oe_q, mid01_oe_q};
  assign COPROC_TRANSFER_REQUEST_O = req_q;
  assign COPROC_ERROR_O            = err_q;
  assign PERIPH_SELECT_N_O         = pcs_q;
  assign PERIPH_SELECT_N_OE_O      = oe_q;
  assign PERIPH_SELECT5_OR_ADDR1_O = dual_q[0];
  assign PERIPH_SELECT6_OR_ADDR2_O = dual_q[1];
  assign PERIPH_DUAL_OE_O          = dual_oe_q;
  assign XCVR_DIRECTION_O          = dir_q;
  assign XCVR_DIRECTION_OE_O       = oe_q;
  assign XCVR_ENABLE_N_O           = den_q;
  assign XCVR_ENABLE_N_OE_O        = den_oe_q;
  assign HOLD_ACK_O                = ack_q;
  assign HOLD_ACK_OE_O             = ack_oe_q;
  assign FLOAT_TEST_MODE_O         = float_q;

  sequence s_release_strapped;
    !RST_I && in_rst && !sync2_q[1] && !sync2_q[2];
  endsequence

  sequence s_steady_access;
    drive && DATA_PHASE_I && (dir_q == WRITE_I);
  endsequence

  property p_float_entry;
    @(posedge REF_CLK_I) disable iff (RST_I)
      s_release_strapped |=> FLOAT_TEST_MODE_O ##1 !UPPER_MEM_SELECT_N_OE_O;
  endproperty
  a_float_entry: assert property (p_float_entry) else $error("float mode not entered");

  property p_float_quiet;
    @(posedge REF_CLK_I) disable iff (RST_I)
      FLOAT_TEST_MODE_O |-> ##1 !(oe_q || dual_oe_q || den_oe_q || ack_oe_q || mid01_oe_q);
  endproperty
  a_float_quiet: assert property (p_float_quiet) else $error("pin driven in float mode");

  property p_upper;
    @(posedge REF_CLK_I) disable iff (RST_I)
      drive && ref_mem && upper_hit(ADDR_I[19:10], UPPER_SIZE_I)
      |=> !UPPER_MEM_SELECT_N_O && UPPER_MEM_SELECT_N_OE_O;
  endproperty
  a_upper: assert property (p_upper) else $error("upper select missed");

  property p_lower;
    @(posedge REF_CLK_I) disable iff (RST_I)
      drive && ref_mem && lower_hit(ADDR_I[19:10], LOWER_SIZE_I) |=> !LOWER_MEM_SELECT_N_O;
  endproperty
  a_lower: assert property (p_lower) else $error("lower select missed");

  property p_idle_high;
    @(posedge REF_CLK_I) disable iff (RST_I)
      !CYCLE_VALID_I |=> UPPER_MEM_SELECT_N_O && LOWER_MEM_SELECT_N_O
                         && (&PERIPH_SELECT_N_O) && (&MID_SELECT_N_O[2:0]);
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("select low with no reference");

  property p_coproc_sel;
    @(posedge REF_CLK_I) disable iff (RST_I)
      ENHANCED_MODE_I && drive && CYCLE_VALID_I && COPROC_ACCESS_I |=> !MID_SELECT_N_O[3];
  endproperty
  a_coproc_sel: assert property (p_coproc_sel) else $error("coprocessor select missed");

  property p_dual_hold;
    @(posedge REF_CLK_I) disable iff (RST_I)
      PERIPH_ADDR_OUT_I && hold_s && run ##1 PERIPH_ADDR_OUT_I
      |=> PERIPH_DUAL_OE_O && $stable(PERIPH_SELECT5_OR_ADDR1_O);
  endproperty
  a_dual_hold: assert property (p_dual_hold) else $error("latched address moved in hold");

  property p_dir_flip;
    @(posedge REF_CLK_I) disable iff (RST_I)
      $changed(XCVR_DIRECTION_O) |-> XCVR_ENABLE_N_O;
  endproperty
  a_dir_flip: assert property (p_dir_flip) else $error("enable low during turn");

  property p_enable;
    @(posedge REF_CLK_I) disable iff (RST_I)
      s_steady_access |=> !XCVR_ENABLE_N_O && (XCVR_DIRECTION_O == $past(WRITE_I));
  endproperty
  a_enable: assert property (p_enable) else $error("enable or direction wrong");

  property p_hold;
    @(posedge REF_CLK_I) disable iff (RST_I)
      run && hold_s |=> HOLD_ACK_O && !UPPER_MEM_SELECT_N_OE_O && !XCVR_ENABLE_N_OE_O;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not answered");

endmodule : csx_top

// ===== bench/csx_pins_model.sv
// Far-side pin model: strap pulls on the upper and lower selects, the
// coprocessor on mid pins 0 and 1, and the resolved level of each pin.
// Assumes the design's output enables and pullup enables as seen at the top.
module csx_pins_model (
  input  wire logic       clk_i,       // Bench clock
  input  wire logic       straps_low_i, // Outside pulls both straps low
  input  wire logic       cop_on_i,    // Coprocessor drives mid pins 0/1
  input  wire logic       cop_req_i,   // Transfer request level
  input  wire logic       cop_err_n_i, // Error level, active low
  input  wire logic [2:0] ucs_i,       // Upper: out, oe, pullup
  input  wire logic [2:0] lcs_i,       // Lower: out, oe, pullup
  input  wire logic [1:0] mid_o_i,     // Mid 0/1 outputs
  input  wire logic [1:0] mid_oe_i,    // Mid 0/1 enables
  output logic            ucs_lvl_o,   // Upper pin level
  output logic            lcs_lvl_o,   // Lower pin level
  output logic            mid0_lvl_o,  // Mid 0 pin level
  output logic            mid1_lvl_o   // Mid 1 pin level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tog_q = 1'b0;

  // An undriven line flips every cycle so a stale value cannot pass
  always @(posedge clk_i) tog_q <= ~tog_q;

  function automatic logic strap(input logic [2:0] p, input logic t);
    if (straps_low_i) return 1'b0;
    if (p[1]) return p[2];
    if (p[0]) return 1'b1;
    return t;
  endfunction : strap

  always_comb begin
    ucs_lvl_o  = strap(ucs_i, tog_q);
    lcs_lvl_o  = strap(lcs_i, ~tog_q);
    mid0_lvl_o = mid_oe_i[0] ? mid_o_i[0] : (cop_on_i ? cop_req_i : tog_q);
    mid1_lvl_o = mid_oe_i[1] ? mid_o_i[1] : (cop_on_i ? cop_err_n_i : tog_q);
  end
endmodule : csx_pins_model

// ===== bench/testbench.sv
// Self-checking bench for the chip-select and transceiver control block.
// Assumes registered outputs one edge after a reference, inputs at negedge.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [19:0] a;
    logic        m, pm, ao;
    logic [12:0] e;
  } csx_row_t;
  logic        clk = 1'b0, rst = 1'b1, enh = 1'b0, vld = 1'b0, mem = 1'b0, wr = 1'b0;
  logic        ph = 1'b0, cop = 1'b0, hold = 1'b0, pim = 1'b1, aout = 1'b0;
  logic        straps_low = 1'b0, cop_on = 1'b0, cop_req = 1'b0, cop_err_n = 1'b1;
  logic [19:0] addr = 20'h00000;
  logic        ucs_lvl, lcs_lvl, m0_lvl, m1_lvl, upper_mem_select_n, ucs_oe, ucs_pu, lower_mem_select_n, lcs_oe, lcs_pu;
  logic        req, err, pcs_oe, d5, d6, d_oe, dir, dir_oe, en_n, en_oe, hold_ack, hold_ack_oe, flt;
  logic [3:0]  mid, mid_oe;
  logic [4:0]  pcs;
  int          fail_count = 0;
  int          cmp_count = 0;
  csx_row_t    rows [13] = '{
    '{20'hff000, 1, 1, 0, 13'h0fff}, '{20'hfefff, 1, 1, 0, 13'h1fff},
    '{20'h3ffff, 1, 1, 0, 13'h17ff}, '{20'h40000, 1, 1, 0, 13'h1f7f},
    '{20'h41800, 1, 1, 0, 13'h1bff}, '{20'h42000, 1, 1, 0, 13'h1fff},
    '{20'h70080, 1, 1, 0, 13'h1ff7}, '{20'h70280, 1, 1, 0, 13'h1ffd},
    '{20'h70380, 1, 1, 0, 13'h1fff}, '{20'h00200, 0, 0, 0, 13'h1fbf},
    '{20'hff000, 0, 0, 0, 13'h1fff}, '{20'h70006, 1, 1, 1, 13'h1ffb},
    '{20'h70300, 1, 1, 1, 13'h1ffc}};

  always #12.5 clk = ~clk;

  csx_top csx_top_i (.REF_CLK_I(clk), .RST_I(rst), .ENHANCED_MODE_I(enh), .CYCLE_VALID_I(vld),
    .ADDR_I(addr), .MEM_CYCLE_I(mem), .WRITE_I(wr), .DATA_PHASE_I(ph), .COPROC_ACCESS_I(cop),
    .HOLD_I(hold), .UPPER_SIZE_I(4'h2), .LOWER_SIZE_I(4'h8), .MID_BASE_I(7'h20),
    .MID_SIZE_I(3'h0), .PERIPH_BASE_I(10'h1c0), .PERIPH_IN_MEM_I(pim),
    .PERIPH_ADDR_OUT_I(aout), .UPPER_MEM_SELECT_N_I(ucs_lvl), .UPPER_MEM_SELECT_N_O(upper_mem_select_n),
    .UPPER_MEM_SELECT_N_OE_O(ucs_oe), .UPPER_PULLUP_EN_O(ucs_pu),
    .LOWER_MEM_SELECT_N_I(lcs_lvl), .LOWER_MEM_SELECT_N_O(lower_mem_select_n),
    .LOWER_MEM_SELECT_N_OE_O(lcs_oe), .LOWER_PULLUP_EN_O(lcs_pu), .MID_SELECT0_N_I(m0_lvl),
    .MID_SELECT1_N_I(m1_lvl), .MID_SELECT_N_O(mid), .MID_SELECT_N_OE_O(mid_oe),
    .COPROC_TRANSFER_REQUEST_O(req), .COPROC_ERROR_O(err), .PERIPH_SELECT_N_O(pcs),
    .PERIPH_SELECT_N_OE_O(pcs_oe), .PERIPH_SELECT5_OR_ADDR1_O(d5),
    .PERIPH_SELECT6_OR_ADDR2_O(d6), .PERIPH_DUAL_OE_O(d_oe), .XCVR_DIRECTION_O(dir),
    .XCVR_DIRECTION_OE_O(dir_oe), .XCVR_ENABLE_N_O(en_n), .XCVR_ENABLE_N_OE_O(en_oe),
    .HOLD_ACK_O(hold_ack), .HOLD_ACK_OE_O(hold_ack_oe), .FLOAT_TEST_MODE_O(flt));

  csx_pins_model csx_pins_model_i (.clk_i(clk), .straps_low_i(straps_low), .cop_on_i(cop_on),
    .cop_req_i(cop_req), .cop_err_n_i(cop_err_n), .ucs_i({upper_mem_select_n, ucs_oe, ucs_pu}),
    .lcs_i({lower_mem_select_n, lcs_oe, lcs_pu}), .mid_o_i(mid[1:0]), .mid_oe_i(mid_oe[1:0]),
    .ucs_lvl_o(ucs_lvl), .lcs_lvl_o(lcs_lvl), .mid0_lvl_o(m0_lvl), .mid1_lvl_o(m1_lvl));

  task automatic close_out();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic bus(input logic [19:0] a, input logic m, input logic c);
    @(negedge clk);
    addr = a;
    mem  = m;
    cop  = c;
    vld  = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    cop = 1'b0;
  endtask : bus

  task automatic wait_ack(input logic v);
    int n;
    n = 0;
    // Bounded so a hold that is never answered ends the run
    while (hold_ack !== v && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk(hold_ack, v, "hold acknowledge");
    if (hold_ack !== v) close_out();
  endtask : wait_ack

  task automatic do_reset(input logic low);
    @(negedge clk);
    rst = 1'b1;
    straps_low = low;
    @(negedge clk);
    chk({en_oe, en_n}, 2'h3, "enable in first reset clock");
    @(negedge clk);
    chk({en_oe, ucs_pu, lcs_pu}, 3'h3, "reset float and pullups");
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    straps_low = 1'b0;
    chk({ucs_pu, lcs_pu}, 2'h0, "pullups after reset");
    chk(flt, low, "float mode entry");
    if (low) begin
      chk({ucs_oe, lcs_oe, mid_oe, pcs_oe, d_oe, dir_oe, en_oe, hold_ack_oe}, 13'h0000, "float");
    end
  endtask : do_reset

  initial begin
    // Power-up state is unknown, so the first-reset-clock checks need a known state
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    do_reset(1'b0);
    foreach (rows[i]) begin
      pim  = rows[i].pm;
      aout = rows[i].ao;
      bus(rows[i].a, rows[i].m, 1'b0);
      chk({upper_mem_select_n, lower_mem_select_n, mid, pcs, d5, d6}, rows[i].e, "decode");
    end
    chk({ucs_oe, lcs_oe, pcs_oe, d_oe, dir_oe}, 5'h1f, "drive in run");
    // Direction turns around while the data phase stays on
    {ph, wr, vld, mem, addr} = {4'hf, 20'h10000};
    @(negedge clk);
    chk({dir, en_n}, 2'h3, "write turnaround");
    @(negedge clk);
    chk({dir, en_n}, 2'h2, "write enable");
    wr = 1'b0;
    @(negedge clk);
    chk({dir, en_n}, 2'h1, "read turnaround");
    @(negedge clk);
    chk({dir, en_n}, 2'h0, "read enable");
    {ph, vld} = 2'h0;
    @(negedge clk);
    chk(en_n, 1'b1, "enable off");
    {enh, cop_on, cop_req, cop_err_n} = 4'he;
    repeat (4) @(negedge clk);
    chk({req, err, mid_oe[1:0]}, 4'hc, "coprocessor pins");
    {cop_req, cop_err_n} = 2'h1;
    repeat (4) @(negedge clk);
    chk({req, err}, 2'h0, "coprocessor idle");
    bus(20'h41800, 1'b1, 1'b0);
    chk(mid[3], 1'b1, "no coprocessor select");
    bus(20'h41800, 1'b1, 1'b1);
    chk(mid[3], 1'b0, "coprocessor select");
    {enh, cop_on, aout} = 3'h1;
    bus(20'h70002, 1'b1, 1'b0);
    hold = 1'b1;
    wait_ack(1'b1);
    chk({pcs_oe, ucs_oe, dir_oe, en_oe, d_oe, d5, d6}, 7'h06, "hold float");
    bus(20'h70004, 1'b1, 1'b0);
    chk({d5, d6, pcs}, 7'h5f, "latched value in hold");
    hold = 1'b0;
    wait_ack(1'b0);
    bus(20'h70004, 1'b1, 1'b0);
    chk({d5, d6}, 2'h1, "latch after hold");
    do_reset(1'b1);
    do_reset(1'b0);
    aout = 1'b0;
    bus(20'hff000, 1'b1, 1'b0);
    chk(upper_mem_select_n, 1'b0, "select after float reset");
    close_out();
  end
endmodule : testbench
